// *** core/adc_device_end.sv ***
`timescale 1ns/1ns
// ****************************************
// converter end: sequencing and readout
// ****************************************
// Behaviour
// - enhanced rates only on sinc5+sinc1 path
// - four enhanced rates with fixed settling times
// - continuous conversion after power-up
// - ready flag cleared; pin driven only selected
// - data read command, ready high afterwards
// - result discarded while data register read
// - enabled channels converted ascending, then wrap
// - append status after data when enabled
// - stream read needs clocks only, no command
// - unread stream word replaced by next
// - host enables stream only in continuous mode
// - stream mode accepts only data reads
// - exit stream by 0x44 or serial reset
// - host keeps data-in low in stream mode
// - single conversion then standby, rereadable
// - single multi-channel: ready high until result
// - status low two bits give channel
// - standby keeps registers; clock select stops oscillator
// - power-down loses registers, outputs released
// - power-down accepted only from standby
// - power-down left only by serial reset
// - host waits 500 us after reset
// - serial reset restores power-on state except status channel bits
module adc_device_end
    import adc_ctl_pkg::*;
#(
    parameter int BASE_SETTLE_CYC = BASE_SETTLE_CYC_DEF,
    parameter int ENH_SETTLE_CYC_0 = ENH_CYC_0,
    parameter int ENH_SETTLE_CYC_1 = ENH_CYC_1,
    parameter int ENH_SETTLE_CYC_2 = ENH_CYC_2,
    parameter int ENH_SETTLE_CYC_3 = ENH_CYC_3
) (
    input wire logic clk,
    input wire logic reset_n,
    spi_link_if.device link,
    input wire logic [23:0] sample_in,
    output logic [1:0] conv_channel,
    output logic conv_active,
    output logic osc_run,
    output logic powered_down,
    output logic [1:0] gpio_o,
    output logic [1:0] gpio_oe
);
    logic [1:0] cs_s, sck_s, din_s;
    logic sck_d;
    logic [7:0] mode_q, ifm_q, chen_q, filt_q, gpio_q, inb_d;
    logic [23:0] data_q;
    logic rdy_n_q, act_q, rdacc_q, conv_q, dout_q, doe_q, osc_q, pd_q;
    logic [1:0] sch_q, ch_q, nxt_ch;
    ser_state_t st_q;
    logic [5:0] cnt_q, len_q;
    logic [7:0] inb_q;
    logic [3:0] addr_q;
    logic [31:0] sh_q;
    logic [6:0] rcnt_q;
    logic [TMR_W-1:0] tmr_q, settle;
    logic frame_rise, srst_hit, conv_done, last_ch, run, stream, pdown;
    mode_t cur_mode;

    function automatic logic [1:0] pick_ch(input logic [7:0] en, input logic [1:0] cur, input logic above);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (en[i]) r = 2'(i);
        end
        for (int i = 3; i >= 0; i--) begin
            if (en[i] && above && i > int'(cur)) r = 2'(i);
        end
        return r;
    endfunction

    assign cur_mode = mode_t'(mode_q[MODE_LSB +: 3]);
    assign pdown = (cur_mode == MODE_PDOWN);
    assign stream = ifm_q[IF_STREAM];
    assign run = (cur_mode == MODE_CONT || cur_mode == MODE_SINGLE) && (chen_q[3:0] != 4'h0);
    assign frame_rise = ~cs_s[1] & sck_s[1] & ~sck_d;
    assign srst_hit = frame_rise & din_s[1] & (rcnt_q == SR_RESET_CLKS - 7'h01);
    assign inb_d = {inb_q[6:0], din_s[1]};
    assign conv_done = conv_q & run & (tmr_q == '0);
    assign nxt_ch = pick_ch(chen_q, ch_q, 1'b1);
    assign last_ch = (nxt_ch <= ch_q);

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_s <= 2'h3;
            sck_s <= 2'h3;
            din_s <= 2'h0;
            sck_d <= 1'b1;
        end else begin
            cs_s <= {cs_s[0], link.cs_n};
            sck_s <= {sck_s[0], link.sclk};
            din_s <= {din_s[0], link.din};
            sck_d <= sck_s[1];
        end
    end

    // ****************************************
    // serial reset detector
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rcnt_q <= '0;
        end else if (cs_s[1] || srst_hit) begin
            rcnt_q <= '0;
        end else if (frame_rise) begin
            rcnt_q <= din_s[1] ? rcnt_q + 7'h01 : 7'h00;
        end
    end

    // ****************************************
    // conversion timing and channel sequence
    // ****************************************
    always_comb begin
        settle = TMR_W'(BASE_SETTLE_CYC);
        if (filt_q[FILT_ENH] && !filt_q[FILT_SINC3]) begin
            case (filt_q[FILT_RATE_LSB +: 2])
                2'h0: settle = TMR_W'(ENH_SETTLE_CYC_0);
                2'h1: settle = TMR_W'(ENH_SETTLE_CYC_1);
                2'h2: settle = TMR_W'(ENH_SETTLE_CYC_2);
                default: settle = TMR_W'(ENH_SETTLE_CYC_3);
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_q <= 1'b0;
            tmr_q <= '0;
            ch_q <= '0;
        end else if (!run || srst_hit) begin
            conv_q <= 1'b0;
        end else if (!conv_q) begin
            conv_q <= 1'b1;
            tmr_q <= settle;
            ch_q <= pick_ch(chen_q, 2'h0, 1'b0);
        end else if (conv_done) begin
            ch_q <= nxt_ch;
            tmr_q <= settle;
            if (cur_mode == MODE_SINGLE && last_ch) conv_q <= 1'b0;
        end else begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // ****************************************
    // registers and serial interface
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= MODE_RST;
            ifm_q <= IFMODE_RST;
            chen_q <= CHEN_RST;
            filt_q <= FILT_RST;
            gpio_q <= GPIO_RST;
            data_q <= '0;
            sch_q <= '0;
            rdy_n_q <= 1'b1;
            st_q <= S_CMD;
            cnt_q <= '0;
            len_q <= LEN_REG;
            inb_q <= '0;
            addr_q <= '0;
            sh_q <= '0;
            act_q <= 1'b0;
            rdacc_q <= 1'b0;
        end else if (srst_hit || pdown) begin
            // power-down holds every register except mode and status channel bits at its power-on value; only serial reset leaves it
            if (srst_hit) mode_q <= MODE_RST;
            ifm_q <= IFMODE_RST;
            chen_q <= CHEN_RST;
            filt_q <= FILT_RST;
            gpio_q <= GPIO_RST;
            data_q <= '0;
            rdy_n_q <= 1'b1;
            st_q <= S_CMD;
            cnt_q <= '0;
            act_q <= 1'b0;
            rdacc_q <= 1'b0;
        end else begin
            if (cs_s[1]) begin
                st_q <= S_CMD;
                cnt_q <= '0;
                act_q <= 1'b0;
                rdacc_q <= 1'b0;
            end else if (stream && ~sck_s[1] && sck_d && !rdy_n_q && cnt_q == 6'h00) begin
                act_q <= 1'b1;
            end else if (frame_rise) begin
                inb_q <= inb_d;
                if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
                if (act_q) sh_q <= {sh_q[30:0], 1'b0};
                case (st_q)
                    S_CMD: begin
                        if (stream) begin
                            if (act_q && cnt_q == len_q - 6'h01) begin
                                act_q <= 1'b0;
                                rdy_n_q <= 1'b1;
                            end
                            if (cnt_q == 6'h07 && inb_d == CMD_EXIT_STREAM && !rdy_n_q) begin
                                ifm_q[IF_STREAM] <= 1'b0;
                                cnt_q <= '0;
                                act_q <= 1'b0;
                            end
                        end else if (cnt_q == 6'h07) begin
                            cnt_q <= '0;
                            addr_q <= inb_d[3:0];
                            if (inb_d[CMD_RD_BIT]) begin
                                st_q <= S_RD;
                                act_q <= 1'b1;
                                rdacc_q <= (inb_d[3:0] == REG_DATA);
                                len_q <= LEN_REG;
                                case (inb_d[3:0])
                                    REG_STATUS: sh_q <= {rdy_n_q, 5'h00, sch_q, 24'h000000};
                                    REG_MODE: sh_q <= {mode_q, 24'h000000};
                                    REG_IFMODE: sh_q <= {ifm_q, 24'h000000};
                                    REG_CHEN: sh_q <= {chen_q, 24'h000000};
                                    REG_FILT: sh_q <= {filt_q, 24'h000000};
                                    REG_GPIO: sh_q <= {gpio_q, 24'h000000};
                                    REG_DATA: begin
                                        sh_q <= {data_q, rdy_n_q, 5'h00, sch_q};
                                        len_q <= ifm_q[IF_APPEND] ? LEN_DATA_ST : LEN_DATA;
                                    end
                                    default: sh_q <= '0;
                                endcase
                            end else begin
                                st_q <= S_WR;
                            end
                        end
                    end
                    S_RD: begin
                        if (cnt_q == len_q - 6'h01) begin
                            st_q <= S_CMD;
                            cnt_q <= '0;
                            act_q <= 1'b0;
                            rdacc_q <= 1'b0;
                            if (rdacc_q) rdy_n_q <= 1'b1;
                        end
                    end
                    S_WR: begin
                        if (cnt_q == 6'h07) begin
                            st_q <= S_CMD;
                            cnt_q <= '0;
                            case (addr_q)
                                REG_MODE: begin
                                    if (inb_d[MODE_LSB +: 3] != MODE_PDOWN || cur_mode == MODE_STANDBY) begin
                                        mode_q <= inb_d;
                                        if (inb_d[MODE_LSB +: 3] == MODE_SINGLE) rdy_n_q <= 1'b1;
                                    end
                                end
                                REG_IFMODE: ifm_q <= inb_d;
                                REG_CHEN: chen_q <= inb_d;
                                REG_FILT: filt_q <= inb_d;
                                REG_GPIO: gpio_q <= inb_d;
                                default: ;
                            endcase
                        end
                    end
                    default: st_q <= S_CMD;
                endcase
            end
            // a finished conversion overrides the serial side in the same cycle
            if (conv_done) begin
                if (!rdacc_q) begin
                    data_q <= sample_in;
                    sch_q <= ch_q;
                    rdy_n_q <= 1'b0;
                    if (stream) begin
                        sh_q <= {sample_in, 1'b0, 5'h00, ch_q};
                        len_q <= ifm_q[IF_APPEND] ? LEN_DATA_ST : LEN_DATA;
                        cnt_q <= '0;
                        act_q <= 1'b0;
                    end
                end
                if (cur_mode == MODE_SINGLE && last_ch)
                    mode_q[MODE_LSB +: 3] <= MODE_STANDBY;
            end
        end
    end

    // ****************************************
    // pin drivers and user outputs
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dout_q <= 1'b1;
            doe_q <= 1'b0;
            osc_q <= 1'b1;
            pd_q <= 1'b0;
        end else begin
            dout_q <= act_q ? sh_q[31] : rdy_n_q;
            doe_q <= ~cs_s[1] & ~pdown;
            pd_q <= pdown;
            // internal oscillator stops in standby when clock select is 00
            osc_q <= ~pdown & ~(cur_mode == MODE_STANDBY && mode_q[CSS_LSB +: 2] == 2'h0);
        end
    end

    assign link.dout_o = dout_q;
    assign link.dout_oe = doe_q;
    assign conv_channel = ch_q;
    assign conv_active = conv_q;
    assign powered_down = pd_q;
    assign osc_run = osc_q;
    assign gpio_o = gpio_q[1:0];
    assign gpio_oe = gpio_q[3:2];
endmodule

// *** core/adc_ctl_pkg.sv ***
// ****************************************
// shared constants
// ****************************************
package adc_ctl_pkg;
    localparam int CLK_MHZ = 50;
    localparam int TMR_W = 22;
    // settling times, sinc5+sinc1 base rate and four enhanced rates
    localparam int BASE_SETTLE_US = 97;
    localparam real ENH_SETTLE_MS_0 = 36.67;
    localparam real ENH_SETTLE_MS_1 = 40.0;
    localparam real ENH_SETTLE_MS_2 = 50.0;
    localparam real ENH_SETTLE_MS_3 = 60.0;
    localparam int BASE_SETTLE_CYC_DEF = BASE_SETTLE_US * CLK_MHZ;
    localparam int ENH_CYC_0 = int'(ENH_SETTLE_MS_0 * 1000.0 * CLK_MHZ);
    localparam int ENH_CYC_1 = int'(ENH_SETTLE_MS_1 * 1000.0 * CLK_MHZ);
    localparam int ENH_CYC_2 = int'(ENH_SETTLE_MS_2 * 1000.0 * CLK_MHZ);
    localparam int ENH_CYC_3 = int'(ENH_SETTLE_MS_3 * 1000.0 * CLK_MHZ);
    localparam int HOST_WAKE_US = 500;
    localparam int HOST_WAKE_CYC_DEF = HOST_WAKE_US * CLK_MHZ;
    localparam logic [6:0] SR_RESET_CLKS = 7'h40;
    localparam logic [7:0] CMD_EXIT_STREAM = 8'h44;
    localparam int CMD_RD_BIT = 6;
    // device register addresses
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_IFMODE = 4'h2;
    localparam logic [3:0] REG_CHEN = 4'h3;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_FILT = 4'h5;
    localparam logic [3:0] REG_GPIO = 4'h6;
    // field positions
    localparam int MODE_LSB = 4;
    localparam int CSS_LSB = 2;
    localparam int IF_STREAM = 7;
    localparam int IF_APPEND = 6;
    localparam int FILT_ENH = 7;
    localparam int FILT_RATE_LSB = 5;
    localparam int FILT_SINC3 = 4;
    localparam int STAT_RDY = 7;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] IFMODE_RST = 8'h00;
    localparam logic [7:0] CHEN_RST = 8'h01;
    localparam logic [7:0] FILT_RST = 8'h00;
    localparam logic [7:0] GPIO_RST = 8'h00;
    localparam logic [5:0] LEN_REG = 6'h08;
    localparam logic [5:0] LEN_DATA = 6'h18;
    localparam logic [5:0] LEN_DATA_ST = 6'h20;
    // host register byte addresses and fields
    localparam logic [4:0] HA_TX = 5'h00;
    localparam logic [4:0] HA_TXDATA = 5'h04;
    localparam logic [4:0] HA_RX = 5'h08;
    localparam logic [4:0] HA_STAT = 5'h0C;
    localparam logic [4:0] HA_CTRL = 5'h10;
    localparam int TX_NB_LSB = 8;
    localparam int TX_SRST = 16;
    localparam int TX_NOCMD = 17;
    localparam int HOST_SCLK_HALF_DEF = 8;

    typedef enum logic [2:0] {
        MODE_CONT = 3'b000,
        MODE_SINGLE = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_PDOWN = 3'b011
    } mode_t;

    typedef enum logic [1:0] {
        S_CMD = 2'b00,
        S_RD = 2'b01,
        S_WR = 2'b10
    } ser_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b011,
        H_WAKE = 3'b100
    } host_state_t;
endpackage

// *** core/spi_link_if.sv ***
`timescale 1ns/1ns
// ****************************************
// serial link between host and converter
// ****************************************
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout_o;
    logic dout_oe;
    logic dout;
    // pull-up keeps the shared line high when the device lets go
    assign dout = dout_oe ? dout_o : 1'b1;
    modport device (input cs_n, input sclk, input din, output dout_o, output dout_oe);
    modport host (output cs_n, output sclk, output din, input dout);
endinterface

// *** core/adc_host_end.sv ***
`timescale 1ns/1ns
// ****************************************
// host end: serial master behind Avalon-MM
// ****************************************
module adc_host_end
    import adc_ctl_pkg::*;
#(
    parameter int SCLK_HALF = HOST_SCLK_HALF_DEF,
    parameter int WAKE_CYC = HOST_WAKE_CYC_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    spi_link_if.host link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    host_state_t st_q;
    logic [1:0] dout_s;
    logic [15:0] div_q;
    logic [6:0] bits_q;
    logic [39:0] osh_q;
    logic [31:0] txd_q, rx_q, rd_q;
    logic cs_q, sck_q, din_q, rst_q, hold_q, wait_q;
    logic req, take, busy, go;

    assign busy = (st_q != H_IDLE);
    assign req = avs_read | avs_write;
    assign take = req & ~wait_q;
    assign go = take & avs_write & (avs_address == HA_TX);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) dout_s <= 2'h3;
        else dout_s <= {dout_s[0], link.dout};
    end

    // ****************************************
    // register slave
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 1'b1;
            rd_q <= '0;
            txd_q <= '0;
            hold_q <= 1'b0;
        end else begin
            // a command write stalls while a frame or the wake-up wait runs
            wait_q <= ~(req & wait_q & ~(avs_write & avs_address == HA_TX & busy));
            if (req & wait_q) begin
                case (avs_address)
                    HA_TXDATA: rd_q <= txd_q;
                    HA_RX: rd_q <= rx_q;
                    HA_STAT: rd_q <= {29'h0, st_q == H_WAKE, ~cs_q & dout_s[1], busy};
                    HA_CTRL: rd_q <= {31'h0, hold_q};
                    default: rd_q <= '0;
                endcase
            end
            if (take & avs_write) begin
                if (avs_address == HA_TXDATA) txd_q <= avs_writedata;
                if (avs_address == HA_CTRL) hold_q <= avs_writedata[0];
            end
        end
    end

    // ****************************************
    // serial engine
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= H_IDLE;
            div_q <= '0;
            bits_q <= '0;
            osh_q <= '0;
            rx_q <= '0;
            cs_q <= 1'b1;
            sck_q <= 1'b1;
            din_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            case (st_q)
                H_IDLE: begin
                    cs_q <= ~hold_q;
                    if (go) begin
                        rst_q <= avs_writedata[TX_SRST];
                        if (avs_writedata[TX_SRST]) begin
                            bits_q <= SR_RESET_CLKS;
                        end else begin
                            bits_q <= (avs_writedata[TX_NOCMD] ? 7'h00 : 7'h08)
                                + {1'b0, avs_writedata[TX_NB_LSB +: 3], 3'h0};
                        end
                        osh_q <= avs_writedata[TX_NOCMD] ? {txd_q, 8'h00} : {avs_writedata[7:0], txd_q};
                        cs_q <= 1'b0;
                        div_q <= '0;
                        st_q <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (st_q == H_LEAD && bits_q == 7'h00) begin
                        st_q <= H_IDLE;
                    end else if (div_q == 16'(SCLK_HALF - 1)) begin
                        div_q <= '0;
                        if (st_q == H_LEAD) begin
                            st_q <= H_LOW;
                            sck_q <= 1'b0;
                            din_q <= rst_q | osh_q[39];
                        end else begin
                            st_q <= H_HIGH;
                            sck_q <= 1'b1;
                            rx_q <= {rx_q[30:0], dout_s[1]};
                            osh_q <= {osh_q[38:0], 1'b0};
                            bits_q <= bits_q - 7'h01;
                        end
                    end else begin
                        div_q <= div_q + 16'h0001;
                    end
                end
                H_HIGH: begin
                    if (div_q == 16'(SCLK_HALF - 1)) begin
                        div_q <= '0;
                        if (bits_q == 7'h00) begin
                            din_q <= 1'b0;
                            cs_q <= ~hold_q;
                            st_q <= rst_q ? H_WAKE : H_IDLE;
                        end else begin
                            st_q <= H_LOW;
                            sck_q <= 1'b0;
                            din_q <= rst_q | osh_q[39];
                        end
                    end else begin
                        div_q <= div_q + 16'h0001;
                    end
                end
                H_WAKE: begin
                    // regulator start-up after a serial reset
                    if (div_q == 16'(WAKE_CYC - 1)) st_q <= H_IDLE;
                    else div_q <= div_q + 16'h0001;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_q;
    assign link.sclk = sck_q;
    assign link.din = din_q;
    assign avs_readdata = rd_q;
    assign avs_waitrequest = wait_q;
endmodule

// *** dv/link_properties.sv ***
`timescale 1ns/1ns
// ****
// link checks
// ****
module link_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic dout
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // device sees cs_n through a synchroniser, so release may lag a few clocks
    property p_oe_on; $rose(dout_oe) |-> !cs_n; endproperty
    property p_oe_off; $rose(cs_n) |-> ##[1:6] !dout_oe; endproperty
    property p_pull; !dout |-> !$past(cs_n, 3); endproperty
    property p_sclk_idle; cs_n |-> sclk; endproperty
    property p_lead; $fell(cs_n) |-> sclk [*8]; endproperty
    property p_low; $fell(sclk) |-> !sclk [*8] ##1 sclk; endproperty
    property p_high; $rose(sclk) |-> sclk [*8]; endproperty
    property p_din; $rose(sclk) |-> $stable(din); endproperty
    a_oe_on: assert property (p_oe_on) else $error("drive while deselected");
    a_oe_off: assert property (p_oe_off) else $error("drive kept");
    a_pull: assert property (p_pull) else $error("line low while deselected");
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk low idle");
    a_lead: assert property (p_lead) else $error("short lead");
    a_low: assert property (p_low) else $error("bad low half");
    a_high: assert property (p_high) else $error("bad high half");
    a_din: assert property (p_din) else $error("din moved at rise");
    c_frame: cover property ($fell(cs_n));
    c_drive: cover property ($rose(dout_oe));
    c_rdy: cover property (dout_oe && !dout_o);
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
// ****
// bench
// ****
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
    import adc_ctl_pkg::*;
    logic clk, reset_n, rd, wr, wait_rq, act, osc, pd;
    logic [4:0] addr;
    logic [31:0] wd, rdata, q;
    logic [23:0] smp;
    logic [1:0] ch, gpoe, gpo, c;
    int errors, num_checks, n, i;
    spi_link_if link();
    adc_device_end #(.BASE_SETTLE_CYC(2000)) adc_device_end_inst (.clk(clk), .reset_n(reset_n),
        .link(link.device), .sample_in(smp), .conv_channel(ch), .conv_active(act), .osc_run(osc),
        .powered_down(pd), .gpio_o(gpo), .gpio_oe(gpoe));
    adc_host_end #(.WAKE_CYC(100)) adc_host_end_inst (.clk(clk), .reset_n(reset_n), .link(link.host),
        .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wait_rq));
    link_properties link_properties_inst (.clk(clk), .reset_n(reset_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe), .dout(link.dout));
    task end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_rq !== 1'b0 && k < 9000);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_rq !== 1'b0) begin
            errors++;
            end_sim();
        end
    endtask
    // bounded poll of host status until masked bits match
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            av(HA_STAT, 1'b0, 32'h0);
            k++;
        end while ((q & m) !== v && k < 4000);
        if ((q & m) !== v) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic xf(input logic [31:0] cmd, input logic [31:0] d);
        av(HA_TXDATA, 1'b1, d);
        av(HA_TX, 1'b1, cmd);
        poll(32'h5, 32'h0);
        av(HA_RX, 1'b0, 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        {rd, wr, addr, wd} = '0;
        smp = 24'hA5C3E1;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        av(5'h14, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        av(HA_CTRL, 1'b1, 32'h1);
        poll(32'h2, 32'h0);
        xf(32'h344, 32'h0);
        `CHK("data", smp, q[23:0])
        av(HA_STAT, 1'b0, 32'h0);
        `CHK("ready back", 1'b1, q[1])
        xf(32'h102, 32'h40000000);
        poll(32'h2, 32'h0);
        xf(32'h444, 32'h0);
        `CHK("append data", smp, q[31:8])
        `CHK("status channel", 2'h0, q[1:0])
        $display("read test done");
        xf(32'h103, 32'h05000000);
        for (i = 0; i < 3; i++) begin
            poll(32'h2, 32'h0);
            xf(32'h444, 32'h0);
            if (i == 2) `CHK("next channel", c ^ 2'h2, q[1:0])
            c = q[1:0];
        end
        $display("sequence test done");
        xf(32'h106, 32'h0D000000);
        `CHK("gpio on", 4'hD, {gpoe, gpo})
        xf(32'h101, 32'h30000000);
        `CHK("pd refused", 1'b0, pd)
        xf(32'h101, 32'h20000000);
        xf(32'h101, 32'h30000000);
        `CHK("pd", 1'b1, pd)
        `CHK("gpio off", 4'h0, {gpoe, gpo})
        xf(32'h10000, 32'h0);
        `CHK("woken", 1'b0, pd)
        xf(32'h143, 32'h0);
        `CHK("chen reset", 8'h01, q[7:0])
        $display("power test done");
        xf(32'h101, 32'h10000000);
        n = 0;
        while (act !== 1'b0 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        `CHK("single ends", 1'b0, act)
        xf(32'h141, 32'h0);
        `CHK("standby after", 8'h20, q[7:0])
        `CHK("osc stop", 1'b0, osc)
        `CHK("channel", 2'h0, ch)
        xf(32'h344, 32'h0);
        `CHK("single data", smp, q[23:0])
        $display("single test done");
        xf(32'h101, 32'h00000000);
        xf(32'h102, 32'h80000000);
        poll(32'h2, 32'h0);
        xf(32'h20300, 32'h0);
        `CHK("stream data", smp, q[23:0])
        av(HA_STAT, 1'b0, 32'h0);
        `CHK("stream ready", 1'b1, q[1])
        poll(32'h2, 32'h0);
        xf(32'h44, 32'h0);
        xf(32'h143, 32'h0);
        `CHK("stream off", 8'h01, q[7:0])
        $display("stream test done");
        end_sim();
    end
endmodule
